// ### rtl/limit_nv_pkg.sv
package limit_nv_pkg;
  // Register indices; byte address is four times the index
  localparam logic [3:0]  IDX_HIGH       = 4'h2;
  localparam logic [3:0]  IDX_LOW        = 4'h3;
  localparam logic [3:0]  IDX_UNLOCK     = 4'h4;
  localparam logic [3:0]  IDX_SCR_ONE    = 4'h5;
  localparam logic [3:0]  IDX_SCR_TWO    = 4'h6;
  // Values after reset, before the nonvolatile load lands
  localparam logic [15:0] HIGH_RESET     = 16'h6000;
  localparam logic [15:0] LOW_RESET      = 16'h8000;
  localparam logic [15:0] UNLOCK_RESET   = 16'h0000;
  localparam logic [15:0] SCRATCH_RESET  = 16'h0000;
  localparam int          UNLOCK_BIT     = 15;
  localparam int          BUSY_BIT       = 14;
  // Nonvolatile slots
  localparam logic [1:0]  SLOT_HIGH      = 2'h0;
  localparam logic [1:0]  SLOT_LOW       = 2'h1;
  localparam logic [1:0]  SLOT_SCR_ONE   = 2'h2;
  localparam logic [1:0]  SLOT_SCR_TWO   = 2'h3;
  // Cycle counts of the nonvolatile array
  localparam logic [7:0]  NV_LOAD_CYCLES = 8'h10;
  localparam logic [7:0]  NV_PROG_CYCLES = 8'h40;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam int          AXI_ADDR_W     = 8;

  typedef struct packed {
    logic [AXI_ADDR_W-1:0] awaddr;
    logic                  awvalid;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  wvalid;
    logic                  bready;
    logic [AXI_ADDR_W-1:0] araddr;
    logic                  arvalid;
    logic                  rready;
  } axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_type;

  typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_PROG} nv_state_type;
endpackage : limit_nv_pkg

// ### rtl/limit_and_nv_scratch_regs.sv
`timescale 1ns/10ps
module limit_and_nv_scratch_regs #(
  parameter logic [15:0] SCR_ONE_FACTORY = 16'h0000,
  parameter logic [15:0] SCR_TWO_FACTORY = 16'h0000
) (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire limit_nv_pkg::axi_req_type bus_req,
  output      limit_nv_pkg::axi_rsp_type bus_rsp,
  input  wire logic                      general_call_reset,
  output      logic [15:0]               high_threshold,
  output      logic [15:0]               low_threshold,
  output      logic [15:0]               scratch_word_one,
  output      logic [15:0]               scratch_word_two,
  output      logic                      nv_program_enable,
  output      logic                      nv_busy
);
  import limit_nv_pkg::*;

  function automatic logic [3:0] reg_index(input logic [AXI_ADDR_W-1:0] a);
    return a[5:2] & {4{a[AXI_ADDR_W-1:6] == '0}};
  endfunction : reg_index

  function automatic logic known_index(input logic [3:0] i);
    return i inside {IDX_HIGH, IDX_LOW, IDX_UNLOCK, IDX_SCR_ONE, IDX_SCR_TWO};
  endfunction : known_index

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // Nonvolatile cells: not cleared by any reset, factory contents preset
  // Slot order follows SLOT_HIGH, SLOT_LOW, SLOT_SCR_ONE, SLOT_SCR_TWO
  logic [15:0]       nv_mem [4] = '{HIGH_RESET, LOW_RESET,
                                    SCR_ONE_FACTORY, SCR_TWO_FACTORY};

  nv_state_type      state;
  nv_state_type      next_state;
  logic [7:0]        count;
  logic [1:0]        prog_slot;
  logic [15:0]       prog_data;
  logic              gc_pending;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: address and data are held apart, so they may come in any order
  logic              aw_full;
  logic              w_full;
  logic [3:0]        aw_idx;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              bvalid;
  logic [1:0]        bresp;
  logic              rvalid;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic [3:0]        rd_idx;

  wire logic         aw_take  = bus_req.awvalid & ~aw_full;
  wire logic         w_take   = bus_req.wvalid & ~w_full;
  wire logic         ar_take  = bus_req.arvalid & ~rvalid;
  // Writes wait while the array is busy or a reload is pending; otherwise the
  // reload would win in the sequencer and an unlocked write would never reach its cell
  wire logic         do_write = aw_full & w_full & ~bvalid & (state == ST_IDLE) & ~gc_pending;
  wire logic         wr_ok    = known_index(aw_idx);
  wire logic         hit_high = do_write & (aw_idx == IDX_HIGH);
  wire logic         hit_low  = do_write & (aw_idx == IDX_LOW);
  wire logic         hit_unl  = do_write & (aw_idx == IDX_UNLOCK);
  wire logic         hit_one  = do_write & (aw_idx == IDX_SCR_ONE);
  wire logic         hit_two  = do_write & (aw_idx == IDX_SCR_TWO);
  wire logic         nv_hit   = hit_high | hit_low | hit_one | hit_two;
  wire logic         start_prog = nv_hit & nv_program_enable;
  wire logic [1:0]   wr_slot  = hit_high ? SLOT_HIGH : hit_low ? SLOT_LOW :
                                hit_one ? SLOT_SCR_ONE : SLOT_SCR_TWO;
  wire logic [3:0]   ar_idx   = reg_index(bus_req.araddr);
  wire logic [15:0]  unlock_view = {nv_program_enable, nv_busy, 14'h0000};
  wire logic [15:0]  rd_word  =
      (ar_idx == IDX_HIGH)    ? high_threshold   :
      (ar_idx == IDX_LOW)     ? low_threshold    :
      (ar_idx == IDX_UNLOCK)  ? unlock_view      :
      (ar_idx == IDX_SCR_ONE) ? scratch_word_one :
      (ar_idx == IDX_SCR_TWO) ? scratch_word_two : 16'h0000;

  assign bus_rsp.awready = ~aw_full;
  assign bus_rsp.wready  = ~w_full;
  assign bus_rsp.bvalid  = bvalid;
  assign bus_rsp.bresp   = bresp;
  assign bus_rsp.arready = ~rvalid;
  assign bus_rsp.rvalid  = rvalid;
  assign bus_rsp.rdata   = rdata;
  assign bus_rsp.rresp   = rresp;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_full <= 1'b0;
      aw_idx  <= 4'h0;
    end else if (aw_take) begin
      aw_full <= 1'b1;
      aw_idx  <= reg_index(bus_req.awaddr);
    end else if (do_write) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      w_full <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (w_take) begin
      w_full <= 1'b1;
      w_data <= bus_req.wdata;
      w_strb <= bus_req.wstrb;
    end else if (do_write) begin
      w_full <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bus_req.bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= RESP_OKAY;
      rd_idx <= 4'h0;
    end else if (ar_take) begin
      rvalid <= 1'b1;
      rdata  <= {16'h0000, rd_word};
      rresp  <= known_index(ar_idx) ? RESP_OKAY : RESP_SLVERR;
      rd_idx <= ar_idx;
    end else if (bus_req.rready) begin
      rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working registers; limits hold raw two's complement codes, one count per
  // 7.8125 millidegrees, so they compare directly with the result
  wire logic load_done = (state == ST_LOAD) && (count == 8'h01);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      high_threshold   <= HIGH_RESET;
      low_threshold    <= LOW_RESET;
      scratch_word_one <= SCRATCH_RESET;
      scratch_word_two <= SCRATCH_RESET;
    end else if (load_done) begin
      high_threshold   <= nv_mem[SLOT_HIGH];
      low_threshold    <= nv_mem[SLOT_LOW];
      scratch_word_one <= nv_mem[SLOT_SCR_ONE];
      scratch_word_two <= nv_mem[SLOT_SCR_TWO];
    end else begin
      // Locked or not, the working copy takes the write
      if (hit_high) high_threshold   <= merge(high_threshold, w_data, w_strb);
      if (hit_low)  low_threshold    <= merge(low_threshold, w_data, w_strb);
      if (hit_one)  scratch_word_one <= merge(scratch_word_one, w_data, w_strb);
      if (hit_two)  scratch_word_two <= merge(scratch_word_two, w_data, w_strb);
    end
  end

  // Only bit 15 is stored; bit 14 reads the busy flag and the rest of the word is constant zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nv_program_enable <= UNLOCK_RESET[UNLOCK_BIT];
    end else if (state == ST_LOAD) begin
      nv_program_enable <= UNLOCK_RESET[UNLOCK_BIT];
    end else if (hit_unl && w_strb[1]) begin
      nv_program_enable <= w_data[UNLOCK_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array sequencer: load after any reset, program on unlocked writes
  always_comb begin
    next_state = state;
    case (state)
      ST_LOAD: if (count == 8'h01) next_state = ST_IDLE;
      ST_IDLE: begin
        if (gc_pending)      next_state = ST_LOAD;
        else if (start_prog) next_state = ST_PROG;
      end
      ST_PROG: if (count == 8'h01) next_state = ST_IDLE;
      default: next_state = ST_LOAD;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state   <= ST_LOAD;
      count   <= NV_LOAD_CYCLES;
      nv_busy <= 1'b1;
    end else begin
      state   <= next_state;
      nv_busy <= (next_state != ST_IDLE);
      if (state == ST_IDLE && next_state == ST_LOAD) count <= NV_LOAD_CYCLES;
      else if (state == ST_IDLE && next_state == ST_PROG) count <= NV_PROG_CYCLES;
      else if (count != 8'h00) count <= count - 8'h01;
    end
  end

  // A general-call pulse during a program is kept and served after it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gc_pending <= 1'b0;
    end else if (general_call_reset) begin
      gc_pending <= 1'b1;
    end else if (state == ST_IDLE) begin
      gc_pending <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prog_slot <= SLOT_HIGH;
      prog_data <= 16'h0000;
    end else if (start_prog) begin
      prog_slot <= wr_slot;
      prog_data <= merge(nv_mem[wr_slot], w_data, w_strb);
    end
  end

  // Cells change only at the end of a program; no reset reaches them
  always_ff @(posedge clk) begin
    if (state == ST_PROG && count == 8'h01) begin
      nv_mem[prog_slot] <= prog_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_unlock_low_zero: assert property (@(posedge clk) disable iff (!resetn)
    rvalid && rd_idx == IDX_UNLOCK |-> rdata[13:0] == 14'h0000)
    else $error("unlock low bits not zero");

  a_busy_mirror: assert property (@(posedge clk) disable iff (!resetn)
    ar_take && ar_idx == IDX_UNLOCK |=> rdata[BUSY_BIT] == $past(nv_busy))
    else $error("unlock busy bit differs from busy flag");

  a_locked_no_prog: assert property (@(posedge clk) disable iff (!resetn)
    nv_hit && !nv_program_enable |=> state != ST_PROG)
    else $error("locked write started programming");

  a_unlocked_prog: assert property (@(posedge clk) disable iff (!resetn)
    nv_hit && nv_program_enable |=> nv_busy [*8])
    else $error("unlocked write did not hold busy");

  a_prog_commit: assert property (@(posedge clk) disable iff (!resetn)
    state == ST_PROG && count == 8'h01 |=> nv_mem[$past(prog_slot)] == $past(prog_data))
    else $error("cell not programmed with written data");

  a_load_high: assert property (@(posedge clk) disable iff (!resetn)
    load_done |=> high_threshold == $past(nv_mem[SLOT_HIGH]) && !nv_busy)
    else $error("high limit not reloaded");

  a_load_low: assert property (@(posedge clk) disable iff (!resetn)
    load_done |=> low_threshold == $past(nv_mem[SLOT_LOW]))
    else $error("low limit not reloaded");

  a_reload_busy: assert property (@(posedge clk) disable iff (!resetn)
    general_call_reset && state == ST_IDLE && !start_prog |-> ##[1:2] nv_busy)
    else $error("general call did not start a load");

  a_pending_reload: assert property (@(posedge clk) disable iff (!resetn)
    gc_pending && state == ST_IDLE |=> state == ST_LOAD)
    else $error("pending reload not served");

  a_write_high: assert property (@(posedge clk) disable iff (!resetn)
    hit_high && w_strb[1:0] == 2'h3 |=> high_threshold == $past(w_data[15:0]))
    else $error("high limit write lost");

  a_scratch_two: assert property (@(posedge clk) disable iff (!resetn)
    hit_two && !nv_program_enable && w_strb[1:0] == 2'h3
      |=> scratch_word_two == $past(w_data[15:0]) && !nv_busy)
    else $error("scratch two locked write wrong");
endmodule : limit_and_nv_scratch_regs

// ### verif/axi_host.sv
`timescale 1ns/10ps
module axi_host (
  input  wire logic                      clk,
  input  wire limit_nv_pkg::axi_rsp_type rsp,
  output      limit_nv_pkg::axi_req_type req
);
  import limit_nv_pkg::*;
  initial req = '0;
  //////////////////////////////////////////////////////////////////////////////
  // Every answer is taken from the values that stand at the rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic b;
    b = 1'b0;
    r = RESP_OKAY;
    @(posedge clk);
    req.awaddr  <= a;
    req.awvalid <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= s;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    while (!b) begin
      @(posedge clk);
      b = rsp.bvalid;
      if (b) r = rsp.bresp;
      // Released address and data show a changed value, never the last one
      if (req.awvalid && rsp.awready) begin
        req.awvalid <= 1'b0;
        req.awaddr  <= ~a;
      end
      if (req.wvalid && rsp.wready) begin
        req.wvalid <= 1'b0;
        req.wdata  <= ~d;
      end
    end
    req.bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic b;
    b = 1'b0;
    d = 32'h00000000;
    r = RESP_OKAY;
    @(posedge clk);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    while (!b) begin
      @(posedge clk);
      b = rsp.rvalid;
      if (b) begin
        d = rsp.rdata;
        r = rsp.rresp;
      end
      if (req.arvalid && rsp.arready) begin
        req.arvalid <= 1'b0;
        req.araddr  <= ~a;
      end
    end
    req.rready <= 1'b0;
  endtask : rd
endmodule : axi_host

// ### verif/tb.sv
`timescale 1ns/10ps
module tb;
  import limit_nv_pkg::*;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] wd;
    logic [3:0]  s;
    logic [15:0] rd;
    logic [1:0]  resp;
  } row_type;
  // Arbitrary identifier values, distinct from zero
  localparam logic [15:0] ID_ONE = 16'hA5C3;
  localparam logic [15:0] ID_TWO = 16'h3C5A;
  logic        clk, resetn, gcr, pe, busy;
  axi_req_type req;
  axi_rsp_type rsp;
  logic [15:0] hi, lo, s1, s2;
  logic [31:0] rdat;
  logic [1:0]  resp;
  int          n_fail = 0, total_checks = 0, cycles = 0;
  row_type     rows [7];
  row_type     prog [4];

  limit_and_nv_scratch_regs #(.SCR_ONE_FACTORY(ID_ONE), .SCR_TWO_FACTORY(ID_TWO))
    limit_and_nv_scratch_regs_i (.clk(clk), .resetn(resetn), .bus_req(req), .bus_rsp(rsp),
    .general_call_reset(gcr), .high_threshold(hi), .low_threshold(lo),
    .scratch_word_one(s1), .scratch_word_two(s2), .nv_program_enable(pe), .nv_busy(busy));
  axi_host axi_host_i (.clk(clk), .rsp(rsp), .req(req));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] ba(input logic [3:0] i);
    return {2'b00, i, 2'b00};
  endfunction : ba

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (busy !== 1'b0 && k < 300);
    check(busy, 0, "busy stuck");
  endtask : wait_idle
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      give_verdict;
    end
  end

  initial begin
    resetn = 1'b0;
    gcr    = 1'b0;
    rows = '{'{ba(IDX_HIGH), 32'h00007FFF, 4'hF, 16'h7FFF, RESP_OKAY},
             '{ba(IDX_LOW), 32'hFFFF8001, 4'hF, 16'h8001, RESP_OKAY},
             '{ba(IDX_SCR_ONE), 32'h00001111, 4'hF, 16'h1111, RESP_OKAY},
             '{ba(IDX_SCR_TWO), 32'h00002222, 4'hF, 16'h2222, RESP_OKAY},
             '{ba(IDX_UNLOCK), 32'h00007FFF, 4'hF, 16'h0000, RESP_OKAY},
             '{ba(IDX_HIGH), 32'h0000ABCD, 4'h1, 16'h7FCD, RESP_OKAY},
             '{8'h1C, 32'h00005555, 4'hF, 16'h0000, RESP_SLVERR}};
    prog = '{'{ba(IDX_HIGH), 32'h00001234, 4'hF, 16'h1234, RESP_OKAY},
             '{ba(IDX_LOW), 32'h0000FF80, 4'hF, 16'hFF80, RESP_OKAY},
             '{ba(IDX_SCR_ONE), 32'h00005678, 4'hF, 16'h5678, RESP_OKAY},
             '{ba(IDX_SCR_TWO), 32'h00009ABC, 4'hF, 16'h9ABC, RESP_OKAY}};
    repeat (16) @(posedge clk);
    check(busy, 1, "busy in reset");
    check(hi, HIGH_RESET, "high in reset");
    check(lo, LOW_RESET, "low in reset");
    check(pe, 0, "unlock in reset");
    resetn <= 1'b1;
    axi_host_i.rd(ba(IDX_UNLOCK), rdat, resp);
    check(rdat, 32'h00004000, "busy during load");
    wait_idle;
    check({hi, lo}, {HIGH_RESET, LOW_RESET}, "limits loaded");
    check({s1, s2}, {ID_ONE, ID_TWO}, "scratch loaded");
    foreach (rows[i]) begin
      axi_host_i.wr(rows[i].a, rows[i].wd, rows[i].s, resp);
      check(resp, rows[i].resp, "bresp");
      check(busy, 0, "locked write busy");
      axi_host_i.rd(rows[i].a, rdat, resp);
      check(rdat, rows[i].rd, "readback");
      check(resp, rows[i].resp, "rresp");
    end
    check(hi, 16'h7FCD, "high port");
    // Reload after locked writes must bring back the untouched cells
    @(posedge clk);
    gcr <= 1'b1;
    @(posedge clk);
    gcr <= 1'b0;
    // Pulse is latched at this edge and starts the load at the next one
    repeat (2) @(negedge clk);
    check(busy, 1, "reload busy");
    wait_idle;
    check({hi, lo}, {HIGH_RESET, LOW_RESET}, "limits reload");
    check({s1, s2}, {ID_ONE, ID_TWO}, "scratch reload");
    axi_host_i.wr(ba(IDX_UNLOCK), 32'h00008000, 4'h3, resp);
    check(pe, 1, "unlock set");
    // Back to back programs: the second waits for the first
    foreach (prog[i]) begin
      axi_host_i.wr(prog[i].a, prog[i].wd, prog[i].s, resp);
      check(busy, 1, "program busy");
      axi_host_i.rd(ba(IDX_UNLOCK), rdat, resp);
      check(rdat, 32'h0000C000, "unlock with busy");
    end
    wait_idle;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    check(hi, HIGH_RESET, "high in second reset");
    resetn <= 1'b1;
    wait_idle;
    check(pe, 0, "unlock after reset");
    foreach (prog[i]) begin
      axi_host_i.rd(prog[i].a, rdat, resp);
      check(rdat, prog[i].rd, "programmed cell");
    end
    give_verdict;
  end
endmodule : tb
